//--- include/t0ps_map.svh
// register offsets, field positions, reset values and timing counts of the timer block
`ifndef T0PS_MAP_SVH
`define T0PS_MAP_SVH

// apb byte offsets
`define T0PS_OFF_COUNT 8'h00
`define T0PS_OFF_OPTION 8'h04
`define T0PS_OFF_INTCTL 8'h08
`define T0PS_OFF_STATUS 8'h0C
`define T0PS_OFF_MASK 8'h10
`define T0PS_OFF_CMD 8'h14

// reset values
`define T0PS_RST_COUNT 8'h00
`define T0PS_RST_OPTION 8'hFF
`define T0PS_RST_INTCTL 8'h00
`define T0PS_RST_MASK 8'h00

// field positions
`define T0PS_INTCTL_OVF_EN 5
`define T0PS_INTCTL_OVF_FLAG 2
`define T0PS_STATUS_OVF 0
`define T0PS_CMD_WDT_CLEAR 0

// timing: pclk period and instruction cycle, both in ns
`define T0PS_PCLK_NS 25
`define T0PS_ICYC_NS 100
`define T0PS_ICYC_DIV (`T0PS_ICYC_NS / `T0PS_PCLK_NS)
`define T0PS_WRITE_HOLDOFF 2

`endif

//--- include/t0ps_pkg.sv
// types shared by the timer block
package t0ps_pkg;
	// option register fields, msb first
	typedef struct packed {
		logic pullup_off;
		logic int_edge;
		logic count_source_select;
		logic source_edge_select;
		logic prescaler_assign;
		logic [2:0] prescale_rate;
	} t0ps_option_t;

	// apb request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} t0ps_apb_req_t;
endpackage : t0ps_pkg

//--- rtl/t0ps_prescaler.sv
// shared eight-bit prescaler, divides its input tick by a power of two
`timescale 1ns/100ps
`include "t0ps_map.svh"
module t0ps_prescaler
	import t0ps_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [3:0] log2_div,
	output logic tick_out
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] wrap_mask;

	// low bits all ones means the next tick completes a period
	always_comb begin
		wrap_mask = 8'(9'h1FF >> (4'd9 - log2_div));
		tick_out = tick_in & ((cnt_r & wrap_mask) == wrap_mask) & ~clear;
		cnt_nxt = cnt_r;
		if (clear) begin
			cnt_nxt = 8'h00;
		end else if (tick_in) begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end

	// count register, software reaches it only through clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_clear_zero: assert property (clear |=> cnt_r == 8'h00)
		else $error("prescaler not cleared");
	a_div_two: assert property ((log2_div == 4'd1) && tick_in && !clear && !cnt_r[0]
		|-> !tick_out)
		else $error("divide by two fired early");
endmodule : t0ps_prescaler

//--- rtl/t0ps_timer.sv
// eight-bit timer/counter with a prescaler shared with the watchdog, apb slave
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "t0ps_map.svh"
module t0ps_timer
	import t0ps_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_ext_clock_pin,
	input wire logic wdt_osc_tick,
	output logic wdt_tick,
	output logic wdt_clear,
	output logic irq
);
	t0ps_apb_req_t req;
	t0ps_option_t opt;
	logic wr_acc;
	logic rd_setup;
	logic addr_ok;

	logic [7:0] count_r, count_nxt;
	logic [7:0] option_r, option_nxt;
	logic [7:0] intctl_r, intctl_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic ovf_flag_r, ovf_flag_nxt;
	logic [1:0] holdoff_r, holdoff_nxt;
	logic [1:0] icyc_r, icyc_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic wdt_clear_r, wdt_clear_nxt;
	logic pin_s1_r, pin_s2_r, pin_s3_r;

	logic icyc_tick;
	logic pin_edge;
	logic src_tick;
	logic ps_in;
	logic ps_clear;
	logic ps_out;
	logic [3:0] ps_log2;
	logic tmr_inc;
	logic ovf;
	logic wr_count;

	// address decode helper shared by read and write paths
	function automatic logic t0ps_mapped(input logic [7:0] a);
		t0ps_mapped = (a == `T0PS_OFF_COUNT) || (a == `T0PS_OFF_OPTION) ||
			(a == `T0PS_OFF_INTCTL) || (a == `T0PS_OFF_STATUS) ||
			(a == `T0PS_OFF_MASK) || (a == `T0PS_OFF_CMD);
	endfunction : t0ps_mapped

	// apb request bundle and phase decode
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign opt = t0ps_option_t'(option_r);
	assign addr_ok = t0ps_mapped(req.addr);
	assign wr_acc = req.sel & req.enable & req.write & addr_ok;
	assign rd_setup = req.sel & ~req.enable & ~req.write;
	assign wr_count = wr_acc & (req.addr == `T0PS_OFF_COUNT);

	// zero wait states, read data captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = req.sel & req.enable & ~addr_ok;
	assign prdata = prdata_r;

	always_comb begin
		icyc_nxt = (icyc_r == 2'(`T0PS_ICYC_DIV - 1)) ? 2'd0 : icyc_r + 2'd1;
	end
	assign icyc_tick = (icyc_r == 2'(`T0PS_ICYC_DIV - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= timer_ext_clock_pin;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	assign pin_edge = opt.source_edge_select ? (pin_s3_r & ~pin_s2_r) :
		(~pin_s3_r & pin_s2_r);

	// source select picks pin or cycle
	assign src_tick = opt.count_source_select ? pin_edge : icyc_tick;

	assign ps_in = opt.prescaler_assign ? wdt_osc_tick : src_tick;
	assign ps_clear = opt.prescaler_assign ? wdt_clear_r : wr_count;
	// timer ratios 1:2 up to 1:256
	// timer one step coarser than watchdog
	assign ps_log2 = {1'b0, opt.prescale_rate} + {3'b000, ~opt.prescaler_assign};

	t0ps_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.clear(ps_clear),
		.tick_in(ps_in),
		.log2_div(ps_log2),
		.tick_out(ps_out)
	);

	// undivided timer only when prescaler away
	assign tmr_inc = (opt.prescaler_assign ? src_tick : ps_out) && (holdoff_r == 2'd0);
	assign wdt_tick = opt.prescaler_assign ? ps_out : wdt_osc_tick;
	assign wdt_clear = wdt_clear_r;
	// a count write in the same cycle overrides the wrap, so no flag
	assign ovf = tmr_inc && !wr_count && (count_r == 8'hFF);

	// count, holdoff and overflow flag next values
	always_comb begin
		count_nxt = count_r;
		holdoff_nxt = holdoff_r;
		ovf_flag_nxt = ovf_flag_r;
		if (wr_count) begin
			holdoff_nxt = 2'(`T0PS_WRITE_HOLDOFF);
		end else if (icyc_tick && holdoff_r != 2'd0) begin
			holdoff_nxt = holdoff_r - 2'd1;
		end
		if (wr_count) begin
			count_nxt = req.wdata[7:0];
		end else if (tmr_inc) begin
			count_nxt = count_r + 8'h01;
		end
		// software clears via either register
		if (wr_acc && req.addr == `T0PS_OFF_INTCTL) begin
			ovf_flag_nxt = req.wdata[`T0PS_INTCTL_OVF_FLAG];
		end else if (wr_acc && req.addr == `T0PS_OFF_STATUS &&
			req.wdata[`T0PS_STATUS_OVF]) begin
			ovf_flag_nxt = 1'b0;
		end
		// wrap sets flag, set beats clear
		if (ovf) begin
			ovf_flag_nxt = 1'b1;
		end
	end

	// configuration and command next values
	always_comb begin
		option_nxt = option_r;
		intctl_nxt = intctl_r;
		mask_nxt = mask_r;
		wdt_clear_nxt = 1'b0;
		if (wr_acc) begin
			unique case (req.addr)
				`T0PS_OFF_OPTION: begin
					option_nxt = req.wdata[7:0];
				end
				`T0PS_OFF_INTCTL: begin
					intctl_nxt = req.wdata[7:0];
				end
				`T0PS_OFF_MASK: begin
					mask_nxt = {7'h00, req.wdata[0]};
				end
				`T0PS_OFF_CMD: begin
					wdt_clear_nxt = req.wdata[`T0PS_CMD_WDT_CLEAR];
				end
				default: begin
					option_nxt = option_r;
				end
			endcase
		end
	end

	always_comb begin
		prdata_nxt = prdata_r;
		if (rd_setup) begin
			prdata_nxt = 32'h0000_0000;
			unique case (req.addr)
				`T0PS_OFF_COUNT: prdata_nxt = {24'h000000, count_r};
				`T0PS_OFF_OPTION: prdata_nxt = {24'h000000, option_r};
				`T0PS_OFF_INTCTL: begin
					prdata_nxt = {24'h000000, intctl_r};
					prdata_nxt[`T0PS_INTCTL_OVF_FLAG] = ovf_flag_r;
				end
				`T0PS_OFF_STATUS: prdata_nxt = {31'h00000000, ovf_flag_r};
				`T0PS_OFF_MASK: prdata_nxt = {24'h000000, mask_r};
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// block state registers other than the pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= `T0PS_RST_COUNT;
			option_r <= `T0PS_RST_OPTION;
			intctl_r <= `T0PS_RST_INTCTL;
			mask_r <= `T0PS_RST_MASK;
			ovf_flag_r <= 1'b0;
			holdoff_r <= 2'd0;
			icyc_r <= 2'd0;
			prdata_r <= 32'h0000_0000;
			wdt_clear_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			option_r <= option_nxt;
			intctl_r <= intctl_nxt;
			mask_r <= mask_nxt;
			ovf_flag_r <= ovf_flag_nxt;
			holdoff_r <= holdoff_nxt;
			icyc_r <= icyc_nxt;
			prdata_r <= prdata_nxt;
			wdt_clear_r <= wdt_clear_nxt;
		end
	end

	// level interrupt from masked sticky flag
	assign irq = ovf_flag_r & mask_r[0];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_count_wrap: assert property (ovf && !wr_count |=> count_r == 8'h00 && ovf_flag_r)
		else $error("wrap did not zero count and set flag");
	a_write_hold: assert property (wr_count |=> holdoff_r == 2'd2)
		else $error("holdoff not loaded by count write");
	a_hold_block: assert property (wr_count ##1 (!wr_count)[*3] |-> count_r == $past(count_r, 1))
		else $error("count moved during holdoff");
	a_timer_mode: assert property (!opt.count_source_select && opt.prescaler_assign &&
		icyc_tick && holdoff_r == 2'd0 && !wr_count |=> count_r == $past(count_r) + 8'h01)
		else $error("timer mode missed an instruction cycle");
	a_fall_edge: assert property (opt.count_source_select && opt.source_edge_select &&
		opt.prescaler_assign && holdoff_r == 2'd0 && pin_s3_r && !pin_s2_r && !wr_count
		|=> count_r == $past(count_r) + 8'h01)
		else $error("falling edge not counted");
	a_rise_ignored: assert property (opt.count_source_select && opt.source_edge_select &&
		!pin_s3_r && pin_s2_r && !wr_count && !icyc_tick |=> count_r == $past(count_r))
		else $error("wrong edge counted");
	a_shared_route: assert property (!opt.prescaler_assign |-> wdt_tick == wdt_osc_tick)
		else $error("watchdog divided while prescaler on timer");
	a_wdt_clear: assert property (wr_acc && req.addr == `T0PS_OFF_CMD && req.wdata[0]
		|=> wdt_clear ##1 !wdt_clear)
		else $error("watchdog clear pulse wrong");
	a_irq_level: assert property (ovf |=> irq == mask_r[0])
		else $error("interrupt not raised by overflow");
endmodule : t0ps_timer

//--- verification/t0ps_ext_clk.sv
// external clock source that drives the counter input pin
`timescale 1ns/100ps
module t0ps_ext_clk (
	input wire logic pclk,
	output logic pin
);
	// pin starts low and stands still between bursts
	initial pin = 1'b0;

	// toggle n times, each level held half pclk periods, prompt or slow
	task automatic toggle(input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge pclk);
			pin <= ~pin;
		end
		repeat (half) @(posedge pclk);
	endtask : toggle
endmodule : t0ps_ext_clk

//--- verification/t0ps_timer_tb.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
`include "t0ps_map.svh"
module t0ps_timer_tb
	import t0ps_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic osc = 1'b0;
	t0ps_apb_req_t req = '0;
	logic [31:0] prdata, q, v;
	logic [31:0] seed = 32'h00008196;
	logic pready, pslverr, ext_pin, wdt_tick, wdt_clear, irq;
	logic [33:0] e;
	logic [33:0] expq[$];
	int failures = 0, checked = 0, ticks = 0, clears = 0, t0, n;

	// 40 MHz clock
	initial forever #12.5 pclk = ~pclk;

	t0ps_timer uut (.pclk(pclk), .presetn(presetn), .psel(req.sel), .penable(req.enable),
		.pwrite(req.write), .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_ext_clock_pin(ext_pin),
		.wdt_osc_tick(osc), .wdt_tick(wdt_tick), .wdt_clear(wdt_clear), .irq(irq));
	t0ps_ext_clk ext (.pclk(pclk), .pin(ext_pin));

	// xorshift source of random values
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// compare seen with expected and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t got %h want %h", $time, seen, exp);
		end
	endtask : check

	// print the verdict and stop
	task automatic finish_test();
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	// one apb transfer, expectation {is_read, slave_error, data} noted first
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] x);
		expq.push_back(x);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.enable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		req <= '0;
		@(posedge pclk);
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 34'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b0, a, 32'h0, {2'b10, d});
	endtask : rd

	// count must rise by k between two reads whose setup edges lie cyc apart
	task automatic span(input int cyc, input logic [7:0] k);
		xfer(1'b0, `T0PS_OFF_COUNT, 32'h0, 34'h0);
		repeat (cyc - 3) @(posedge pclk);
		rd(`T0PS_OFF_COUNT, {24'h0, q[7:0] + k});
	endtask : span

	// irq looked at mid-cycle, the next drive starts on a rising edge again
	task automatic chk_irq(input logic x);
		@(negedge pclk);
		check({31'h0, irq}, {31'h0, x});
		@(posedge pclk);
	endtask : chk_irq

	// watchdog timebase pulses with random gaps
	task automatic feed(input int m);
		repeat (m) begin
			osc <= 1'b1;
			@(posedge pclk);
			osc <= 1'b0;
			repeat (1 + (rnd() & 32'h3)) @(posedge pclk);
		end
	endtask : feed

	// compare each completed transfer with the oldest note, count watchdog pulses
	always @(posedge pclk) begin
		if (wdt_tick === 1'b1) ticks++;
		if (wdt_clear === 1'b1) clears++;
		if (req.sel && req.enable && pready === 1'b1) begin
			e = expq.pop_front();
			check({31'h0, pslverr}, {31'h0, e[32]});
			if (e[33]) check(prdata, e[31:0]);
		end
	end

	// hang guard
	initial begin
		repeat (40000) @(posedge pclk);
		failures++;
		finish_test();
	end

	// main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`T0PS_OFF_OPTION, 32'h000000FF);
		rd(`T0PS_OFF_COUNT, 32'h0);
		rd(`T0PS_OFF_INTCTL, 32'h0);
		rd(`T0PS_OFF_MASK, 32'h0);
		xfer(1'b0, 8'h18, 32'h0, {2'b11, 32'h0});
		xfer(1'b1, 8'h1C, rnd(), {2'b01, 32'h0});
		v = rnd();
		wr(`T0PS_OFF_COUNT, v);
		rd(`T0PS_OFF_COUNT, {24'h0, v[7:0]});
		wr(`T0PS_OFF_INTCTL, v);
		rd(`T0PS_OFF_INTCTL, {24'h0, v[7:0]});
		rd(`T0PS_OFF_STATUS, {31'h0, v[`T0PS_INTCTL_OVF_FLAG]});
		wr(`T0PS_OFF_INTCTL, 32'h0);
		v = rnd();
		wr(`T0PS_OFF_OPTION, v);
		rd(`T0PS_OFF_OPTION, {24'h0, v[7:0]});
		// undivided timer, prescaler on the watchdog
		wr(`T0PS_OFF_OPTION, 32'hC8);
		span(80, 8'h14);
		// two idle instruction cycles after a count write
		wr(`T0PS_OFF_COUNT, 32'h40);
		repeat (39) @(posedge pclk);
		rd(`T0PS_OFF_COUNT, 32'h48);
		for (int r = 0; r < 8; r++) begin
			wr(`T0PS_OFF_OPTION, 32'hC0 | r);
			span(12 << (r + 1), 8'h03);
		end
		// count write restarts the 1:256 prescaler
		wr(`T0PS_OFF_COUNT, 32'h0);
		repeat (800) @(posedge pclk);
		rd(`T0PS_OFF_COUNT, 32'h0);
		// safe hand-over of the prescaler from the timer to the watchdog
		wr(`T0PS_OFF_CMD, 32'h1);
		wr(`T0PS_OFF_COUNT, 32'h0);
		wr(`T0PS_OFF_OPTION, 32'hCF);
		wr(`T0PS_OFF_CMD, 32'h1);
		wr(`T0PS_OFF_OPTION, 32'hC8);
		rd(`T0PS_OFF_OPTION, 32'hC8);
		for (int s = 0; s < 2; s++) begin
			n = 4 + (rnd() & 32'h7);
			wr(`T0PS_OFF_OPTION, 32'hE8 | (s << 4));
			wr(`T0PS_OFF_COUNT, 32'h0);
			repeat (12) @(posedge pclk);
			ext.toggle(2 * n - 1, 4 + 6 * s);
			rd(`T0PS_OFF_COUNT, n);
		end
		// wrap sets the flag with the enable clear, mask gates irq
		wr(`T0PS_OFF_OPTION, 32'hC8);
		wr(`T0PS_OFF_STATUS, 32'h1);
		wr(`T0PS_OFF_MASK, 32'h1);
		chk_irq(1'b0);
		wr(`T0PS_OFF_COUNT, 32'hFE);
		repeat (40) @(posedge pclk);
		chk_irq(1'b1);
		rd(`T0PS_OFF_STATUS, 32'h1);
		rd(`T0PS_OFF_INTCTL, 32'h4);
		wr(`T0PS_OFF_MASK, 32'h0);
		chk_irq(1'b0);
		wr(`T0PS_OFF_STATUS, 32'h1);
		wr(`T0PS_OFF_MASK, 32'h1);
		chk_irq(1'b0);
		rd(`T0PS_OFF_STATUS, 32'h0);
		// watchdog ratios restart on each clear
		for (int r = 0; r < 8; r++) begin
			wr(`T0PS_OFF_OPTION, 32'hC8 | r);
			wr(`T0PS_OFF_CMD, 32'h1);
			repeat (3) @(posedge pclk);
			t0 = ticks;
			feed(2 << r);
			check(ticks - t0, 32'h2);
		end
		// two clears from the hand-over plus one per ratio
		check(clears, 32'hA);
		rd(`T0PS_OFF_CMD, 32'h0);
		// raw timebase to the watchdog while the timer owns the prescaler
		wr(`T0PS_OFF_OPTION, 32'hC0);
		t0 = ticks;
		feed(5);
		check(ticks - t0, 32'h5);
		finish_test();
	end
endmodule : t0ps_timer_tb
